/* File: hw/ors_consts.vh */
// Shared constants for the output ramp sequencer
`ifndef ORS_CONSTS_VH
`define ORS_CONSTS_VH

// Register word indices on the plain register port
`define ORS_REG_CTRL        4'h0
`define ORS_REG_TON_DLY     4'h1
`define ORS_REG_RISE        4'h2
`define ORS_REG_TOFF_DLY    4'h3
`define ORS_REG_FALL        4'h4
`define ORS_REG_SETPOINT    4'h5
`define ORS_REG_TON_MAX     4'h6
`define ORS_REG_PWM_MODE    4'h7
`define ORS_REG_STATUS      4'h8
`define ORS_REG_TARGET      4'h9
`define ORS_REG_DAC_TRIM    4'ha

// Control register fields
`define ORS_CTRL_ON_BIT     0
`define ORS_CTRL_RESP_BIT   1
`define ORS_CTRL_FLTRSP_BIT 2

// Pwm mode configuration fields
`define ORS_PWM_CCM_BIT     0
`define ORS_PWM_RANGE_BIT   1
`define ORS_PWM_SERVO_BIT   6

// Reset values
`define ORS_CTRL_RST        8'h00
`define ORS_PWM_RST         8'h00

// Timing: delays and ramps counted in 0.1 ms timebase ticks, power-good filter and servo in clocks
`define ORS_STEP_US         100
`define ORS_RISE_MIN_TICKS  16'h0003
`define ORS_RAMP_MAX_TICKS  16'h32c8
`define ORS_PGOOD_US        60
`define ORS_SERVO_MS        90
`define ORS_CLK_MHZ         100

`endif

/* File: hw/ors_output_ramp_sequencer.v */
// Output ramp sequencer: run line, delays, soft start/stop, digital servo
//
// Contract
// - Hold run line low until initialized and input above turn-on threshold.
// - Shared run line: hold low until all devices ready (wired-and).
// - After run release, wait turn-on delay before starting ramp.
// - Time all delays from the common shared timebase clock.
// - Soft start steps target from zero up to set point over rise time.
// - Rise time below 0.250 ms skips the soft-start ramp.
// - Rise ramp has rise time over 0.1 ms steps.
// - Discontinuous mode throughout the rise ramp.
// - Power-good indication filtered internally for 60 us.
// - Servo enabled only when pwm mode config bit 6 set.
// - Servo steps DAC one LSB every 90 ms until reading correct.
// - Servo starts after turn-on limit, or rise done and above UV if zero.
// - At servo start, leave discontinuous mode for pwm mode bit 0 mode.
// - Nonzero limit, ignore response: rise done, limit reached, UV or OC clear.
// - Nonzero limit, active response: rise done, limit expired, no UV and no OC.
// - Clamp rise and fall times to 1.3 seconds.
// - Run low or commanded off performs fall ramp of fall/0.1 ms steps.
// - Fault shutdown or external fault with response three-states output now.
// - At end of fall interval stop sinking current.
// - In discontinuous mode at turn-off, draw no negative current.
// - Input below turn-off threshold pulls timebase low until above turn-on.
`timescale 1ns/10ps
`include "ors_consts.vh"

module ors_output_ramp_sequencer
#(
    parameter PGOOD_FILT_CYC = `ORS_PGOOD_US * `ORS_CLK_MHZ,
    parameter SERVO_CYC      = `ORS_SERVO_MS * 1000 * `ORS_CLK_MHZ
)
(
    input  wire        clk_in,
    input  wire        rstn_in,
    input  wire [3:0]  addr_in,
    input  wire [15:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [15:0] rdata_out,
    input  wire        init_done_in,
    input  wire        vin_above_on_in,
    input  wire        vin_below_off_in,
    input  wire        run_line_in,
    output reg         run_line_oe_out,
    output reg         run_line_out,
    input  wire        timebase_in,
    output reg         timebase_oe_out,
    output reg         timebase_out,
    input  wire        fault_line_in,
    input  wire        fault_shutdown_in,
    input  wire        uv_exceeded_in,
    input  wire        uv_fault_in,
    input  wire        oc_active_in,
    input  wire        adc_low_in,
    input  wire        adc_high_in,
    input  wire        vout_good_in,
    output reg         power_good_out,
    output reg  [15:0] target_out,
    output reg  [15:0] dac_trim_out,
    output reg         ccm_out,
    output reg         three_state_out,
    output reg         sink_en_out
);

localparam ST_HOLD   = 3'h0;
localparam ST_TONDLY = 3'h1;
localparam ST_RISE   = 3'h2;
localparam ST_ON     = 3'h3;
localparam ST_TOFDLY = 3'h4;
localparam ST_FALL   = 3'h5;
localparam ST_OFF    = 3'h6;

// Pin synchronisers, first stage feeds only the second
reg  [6:0] s1_q;
reg  [6:0] s2_q;
always @(posedge clk_in)
begin
    if (!rstn_in)
    begin
        s1_q <= 7'h00;
        s2_q <= 7'h00;
    end
    else
    begin
        s1_q <= {vin_below_off_in, vin_above_on_in, run_line_in, timebase_in,
                 fault_line_in, init_done_in, vout_good_in};
        s2_q <= s1_q;
    end
end
wire input_turn_off_threshold_s  = s2_q[6];
wire input_turn_on_threshold_s   = s2_q[5];
wire run_s      = s2_q[4];
wire tb_s       = s2_q[3];
wire fault_s    = s2_q[2];
wire init_s     = s2_q[1];
wire vgood_s    = s2_q[0];

reg  [7:0]  ctrl_q;
reg  [15:0] ton_dly_q;
reg  [15:0] rise_q;
reg  [15:0] toff_dly_q;
reg  [15:0] fall_q;
reg  [15:0] setpoint_q;
reg  [15:0] ton_max_q;
reg  [7:0]  pwm_q;
reg  [2:0]  st_q;
reg         tb_prev_q;
reg         vin_lock_q;
reg  [15:0] tick_q;
reg  [15:0] steps_q;
reg  [15:0] onmax_q;
reg         servo_on_q;
reg  [31:0] servo_cnt_q;
reg  [15:0] pg_cnt_q;

wire [15:0] rise_eff = (rise_q > `ORS_RAMP_MAX_TICKS) ? `ORS_RAMP_MAX_TICKS : rise_q;
wire [15:0] fall_eff = (fall_q > `ORS_RAMP_MAX_TICKS) ? `ORS_RAMP_MAX_TICKS : fall_q;

// one tick per rising timebase edge
wire tick = tb_s & ~tb_prev_q;

wire want_on  = ctrl_q[`ORS_CTRL_ON_BIT] & run_s;
wire hard_off = fault_shutdown_in | (~fault_s & ctrl_q[`ORS_CTRL_FLTRSP_BIT]);
wire ready    = init_s & input_turn_on_threshold_s & ~vin_lock_q;

wire lim_zero  = (ton_max_q == 16'h0000);
wire lim_done  = (onmax_q >= ton_max_q);
wire servo_go  = (st_q == ST_ON) &&
                 (lim_zero ? uv_exceeded_in :
                  ctrl_q[`ORS_CTRL_RESP_BIT] ? (lim_done & ~uv_fault_in & ~oc_active_in) :
                  (lim_done & (uv_exceeded_in | ~oc_active_in)));

// Register port
always @(posedge clk_in)
begin
    if (!rstn_in)
    begin
        ctrl_q     <= `ORS_CTRL_RST;
        ton_dly_q  <= 16'h0000;
        rise_q     <= 16'h0000;
        toff_dly_q <= 16'h0000;
        fall_q     <= 16'h0000;
        setpoint_q <= 16'h0000;
        ton_max_q  <= 16'h0000;
        pwm_q      <= `ORS_PWM_RST;
        rdata_out  <= 16'h0000;
    end
    else
    begin
        if (wr_in)
        begin
            case (addr_in)
                `ORS_REG_CTRL:     ctrl_q     <= wdata_in[7:0];
                `ORS_REG_TON_DLY:  ton_dly_q  <= wdata_in;
                `ORS_REG_RISE:     rise_q     <= wdata_in;
                `ORS_REG_TOFF_DLY: toff_dly_q <= wdata_in;
                `ORS_REG_FALL:     fall_q     <= wdata_in;
                `ORS_REG_SETPOINT: setpoint_q <= wdata_in;
                `ORS_REG_TON_MAX:  ton_max_q  <= wdata_in;
                `ORS_REG_PWM_MODE: pwm_q      <= wdata_in[7:0];
                default:           ;
            endcase
        end
        if (rd_in)
        begin
            case (addr_in)
                `ORS_REG_CTRL:     rdata_out <= {8'h00, ctrl_q};
                `ORS_REG_TON_DLY:  rdata_out <= ton_dly_q;
                `ORS_REG_RISE:     rdata_out <= rise_q;
                `ORS_REG_TOFF_DLY: rdata_out <= toff_dly_q;
                `ORS_REG_FALL:     rdata_out <= fall_q;
                `ORS_REG_SETPOINT: rdata_out <= setpoint_q;
                `ORS_REG_TON_MAX:  rdata_out <= ton_max_q;
                `ORS_REG_PWM_MODE: rdata_out <= {8'h00, pwm_q};
                `ORS_REG_STATUS:   rdata_out <= {8'h00, servo_on_q, power_good_out,
                                                 vin_lock_q, run_s, 1'b0, st_q};
                `ORS_REG_TARGET:   rdata_out <= target_out;
                `ORS_REG_DAC_TRIM: rdata_out <= dac_trim_out;
                default:           rdata_out <= 16'h0000;
            endcase
        end
        else
        begin
            rdata_out <= 16'h0000;
        end
    end
end

// Sequencer
always @(posedge clk_in)
begin
    if (!rstn_in)
    begin
        st_q            <= ST_HOLD;
        tb_prev_q       <= 1'b0;
        vin_lock_q      <= 1'b1;
        tick_q          <= 16'h0000;
        steps_q         <= 16'h0000;
        onmax_q         <= 16'h0000;
        target_out      <= 16'h0000;
        run_line_oe_out <= 1'b1;
        run_line_out    <= 1'b0;
        timebase_oe_out <= 1'b1;
        timebase_out    <= 1'b0;
        ccm_out         <= 1'b0;
        three_state_out <= 1'b1;
        sink_en_out     <= 1'b0;
    end
    else
    begin
        tb_prev_q    <= tb_s;
        run_line_out <= 1'b0;
        timebase_out <= 1'b0;
        // lock out below turn-off until above turn-on again
        if (input_turn_off_threshold_s)
            vin_lock_q <= 1'b1;
        else if (input_turn_on_threshold_s)
            vin_lock_q <= 1'b0;
        timebase_oe_out <= input_turn_off_threshold_s | vin_lock_q;
        // release open-drain run line only when ready
        run_line_oe_out <= ~ready;
        // programmed mode once servo point reached
        // Held through turn-off so a continuous-mode fall can still sink
        if (st_q == ST_ON)
            ccm_out <= servo_on_q & pwm_q[`ORS_PWM_CCM_BIT];
        else if (st_q != ST_TOFDLY && st_q != ST_FALL)
            ccm_out <= 1'b0;
        if (tick && st_q == ST_ON && !lim_done)
            onmax_q <= onmax_q + 16'h0001;
        if (hard_off || !ready)
        begin
            st_q            <= ST_HOLD;
            target_out      <= 16'h0000;
            three_state_out <= 1'b1;
            sink_en_out     <= 1'b0;
            tick_q          <= 16'h0000;
        end
        else
        begin
            case (st_q)
                ST_HOLD, ST_OFF:
                begin
                    three_state_out <= 1'b1;
                    sink_en_out     <= 1'b0;
                    target_out      <= 16'h0000;
                    tick_q          <= 16'h0000;
                    onmax_q         <= 16'h0000;
                    if (want_on)
                        st_q <= ST_TONDLY;
                end
                ST_TONDLY:
                begin
                    if (!want_on)
                        st_q <= ST_OFF;
                    else if (tick_q >= ton_dly_q)
                    begin
                        tick_q          <= 16'h0000;
                        steps_q         <= 16'h0000;
                        three_state_out <= 1'b0;
                        // skip soft start for short rise
                        if (rise_eff < `ORS_RISE_MIN_TICKS)
                        begin
                            target_out <= setpoint_q;
                            st_q       <= ST_ON;
                        end
                        else
                            st_q <= ST_RISE;
                    end
                    else if (tick)
                        tick_q <= tick_q + 16'h0001;
                end
                ST_RISE:
                begin
                    // one step per tick, DCM via ccm_out low
                    if (!want_on)
                        st_q <= ST_TOFDLY;
                    else if (steps_q >= rise_eff)
                    begin
                        target_out <= setpoint_q;
                        st_q       <= ST_ON;
                    end
                    else if (tick)
                    begin
                        steps_q    <= steps_q + 16'h0001;
                        target_out <= ramp_val(setpoint_q, steps_q + 16'h0001, rise_eff);
                    end
                end
                ST_ON:
                begin
                    target_out <= setpoint_q;
                    tick_q     <= 16'h0000;
                    if (!want_on)
                        st_q <= ST_TOFDLY;
                end
                ST_TOFDLY:
                begin
                    if (tick_q >= toff_dly_q)
                    begin
                        tick_q      <= 16'h0000;
                        steps_q     <= 16'h0000;
                        sink_en_out <= ccm_out;
                        st_q        <= ST_FALL;
                    end
                    else if (tick)
                        tick_q <= tick_q + 16'h0001;
                end
                ST_FALL:
                begin
                    if (steps_q >= fall_eff)
                    begin
                        // stop sinking at end of fall
                        target_out      <= 16'h0000;
                        sink_en_out     <= 1'b0;
                        three_state_out <= 1'b1;
                        st_q            <= ST_OFF;
                    end
                    else if (tick)
                    begin
                        steps_q    <= steps_q + 16'h0001;
                        target_out <= setpoint_q -
                                      ramp_val(setpoint_q, steps_q + 16'h0001, fall_eff);
                    end
                end
                default:
                    st_q <= ST_HOLD;
            endcase
        end
    end
end

// Linear ramp point: sp * n / total
function [15:0] ramp_val;
    input [15:0] sp;
    input [15:0] n;
    input [15:0] total;
    reg   [31:0] prod;
    reg   [31:0] quo;
    begin
        prod = sp * n;
        quo = prod / {16'h0000, total};
        ramp_val = (total == 16'h0000) ? sp : quo[15:0];
    end
endfunction

// Servo: set-over-clear not needed, servo flag owned by hardware only
always @(posedge clk_in)
begin
    if (!rstn_in)
    begin
        servo_on_q   <= 1'b0;
        servo_cnt_q  <= 32'h00000000;
        dac_trim_out <= 16'h0000;
    end
    else
    begin
        if (st_q != ST_ON)
            servo_on_q <= 1'b0;
        else if (servo_go)
            servo_on_q <= 1'b1;
        // step one LSB each servo period
        if (!servo_on_q || !pwm_q[`ORS_PWM_SERVO_BIT])
            servo_cnt_q <= 32'h00000000;
        else if (servo_cnt_q >= SERVO_CYC - 1)
        begin
            servo_cnt_q <= 32'h00000000;
            if (adc_low_in)
                dac_trim_out <= dac_trim_out + 16'h0001;
            else if (adc_high_in)
                dac_trim_out <= dac_trim_out - 16'h0001;
        end
        else
            servo_cnt_q <= servo_cnt_q + 32'h00000001;
    end
end

// power good must hold steady for the filter time
always @(posedge clk_in)
begin
    if (!rstn_in)
    begin
        pg_cnt_q       <= 16'h0000;
        power_good_out <= 1'b0;
    end
    else if (vgood_s == power_good_out)
        pg_cnt_q <= 16'h0000;
    else if (pg_cnt_q >= PGOOD_FILT_CYC - 1)
    begin
        pg_cnt_q       <= 16'h0000;
        power_good_out <= vgood_s;
    end
    else
        pg_cnt_q <= pg_cnt_q + 16'h0001;
end

endmodule // ors_output_ramp_sequencer

/* File: testbench/ors_checker.sv */
// Port assertions for the output ramp sequencer
`timescale 1ns/10ps
module ors_checker
#(
    parameter PGOOD_FILT_CYC = 6000,
    parameter SERVO_CYC      = 9000000
)
(
    input wire        clk_in,
    input wire        rstn_in,
    input wire [3:0]  addr_in,
    input wire [15:0] wdata_in,
    input wire        wr_in,
    input wire        rd_in,
    input wire [15:0] rdata_out,
    input wire        init_done_in,
    input wire        vin_below_off_in,
    input wire        run_line_oe_out,
    input wire        timebase_oe_out,
    input wire        fault_shutdown_in,
    input wire        vout_good_in,
    input wire        power_good_out,
    input wire [15:0] target_out,
    input wire [15:0] dac_trim_out,
    input wire        ccm_out,
    input wire        three_state_out,
    input wire        sink_en_out
);
    reg [7:0]  pwm_q;
    reg [1:0]  init_q;
    reg [15:0] good_q;
    reg [15:0] dac_q;
    reg [31:0] srv_q;

    // Shadow of the mode word, so mode and servo decisions can be judged
    always @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pwm_q  <= 8'h00;
            init_q <= 2'h0;
            good_q <= 16'h0000;
            srv_q  <= 32'h0;
        end
        else
        begin
            if (wr_in && addr_in == 4'h7)
                pwm_q <= wdata_in[7:0];
            init_q <= !init_done_in ? 2'h0 : (&init_q ? init_q : init_q + 2'h1);
            good_q <= !vout_good_in ? 16'h0 : (&good_q ? good_q : good_q + 16'h1);
            srv_q  <= (dac_trim_out != dac_q) ? 32'h0 : srv_q + 32'h1;
        end
        dac_q <= dac_trim_out;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_run_hold: assert property (!run_line_oe_out |-> init_q >= 2'h2)
        else $error("run line released early");
    a_dcm_rise: assert property ($changed(target_out) && target_out > $past(target_out) |-> !ccm_out)
        else $error("continuous mode during rise");
    a_servo_gate: assert property ($changed(dac_trim_out) && !three_state_out |-> pwm_q[6])
        else $error("trim moved with servo off");
    a_servo_step: assert property ($changed(dac_trim_out) && !three_state_out |->
        (dac_trim_out - $past(dac_trim_out) == 16'h1) || ($past(dac_trim_out) - dac_trim_out == 16'h1))
        else $error("trim step not one lsb");
    a_servo_space: assert property ($changed(dac_trim_out) && !three_state_out |-> srv_q >= SERVO_CYC - 1)
        else $error("trim steps too close");
    a_ccm_mode: assert property ($rose(ccm_out) |-> pwm_q[0])
        else $error("continuous mode not programmed");
    a_pg_filter: assert property ($rose(power_good_out) |-> good_q >= PGOOD_FILT_CYC)
        else $error("power good not filtered");
    a_fault_off: assert property (fault_shutdown_in |-> ##[0:2] three_state_out)
        else $error("no three-state on fault");
    a_no_negsink: assert property (sink_en_out |-> ccm_out)
        else $error("sinking in discontinuous mode");
    a_tb_pull: assert property (vin_below_off_in [*5] |-> timebase_oe_out)
        else $error("timebase not pulled low");
    a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read slot");

    c_rise: cover property ($changed(target_out) && !ccm_out);
    c_servo: cover property ($changed(dac_trim_out));
    c_pg: cover property ($rose(power_good_out));
endmodule // ors_checker

/* File: testbench/ors_peer_model.sv */
// Peer regulator on the shared run line and timebase
`timescale 1ns/10ps
module ors_peer_model
#(
    parameter TB_HALF = 10
)
(
    input  wire clk_in,
    input  wire hold_run_in,
    output reg  run_oe_out,
    output reg  tb_level_out
);
    integer cnt_q = 0;

    initial
    begin
        run_oe_out   = 1'b1;
        tb_level_out = 1'b1;
    end

    always @(posedge clk_in)
    begin
        // holds run low while not ready
        run_oe_out <= hold_run_in;
        cnt_q <= (cnt_q == TB_HALF - 1) ? 0 : cnt_q + 1;
        if (cnt_q == TB_HALF - 1)
            tb_level_out <= ~tb_level_out;
    end
endmodule // ors_peer_model

/* File: testbench/testbench.sv */
// Self-checking bench for the output ramp sequencer
`timescale 1ns/10ps
module testbench;
    localparam PER = 20;
    localparam SRV = 20;
    reg         clk_in;
    reg         rstn_in = 1'b0;
    reg  [3:0]  addr_in = 4'h0;
    reg  [15:0] wdata_in = 16'h0;
    reg         wr_in = 1'b0;
    reg         rd_in = 1'b0;
    reg         init_done_in = 1'b0;
    reg         vin_above_on_in = 1'b0;
    reg         vin_below_off_in = 1'b0;
    reg         fault_shutdown_in = 1'b0;
    reg         uv_exceeded_in = 1'b0;
    reg         adc_low_in = 1'b0;
    reg         vout_good_in = 1'b0;
    reg         oc_active_in = 1'b0;
    reg         hold_run = 1'b1;
    reg         rd_d = 1'b0;
    reg         mon_t = 1'b1;
    reg  [15:0] last_t = 16'h0;
    reg  [15:0] k;
    reg  [15:0] rv;
    wire [15:0] rdata_out;
    wire [15:0] target_out;
    wire [15:0] dac_trim_out;
    wire        run_line_oe_out;
    wire        timebase_oe_out;
    wire        power_good_out;
    wire        ccm_out;
    wire        three_state_out;
    wire        sink_en_out;
    wire        peer_run_oe;
    wire        peer_tb;
    wire        run_wire = !(run_line_oe_out || peer_run_oe);
    wire        tb_wire = peer_tb && !timebase_oe_out;
    integer     errors = 0;
    integer     n_tests = 0;
    integer     i;
    reg  [15:0] rexp[$];
    reg  [15:0] texp[$];

    ors_output_ramp_sequencer #(.PGOOD_FILT_CYC(4), .SERVO_CYC(SRV)) u_dut
    (
        .clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .init_done_in, .vin_above_on_in, .vin_below_off_in, .run_line_in(run_wire),
        .run_line_oe_out, .run_line_out(), .timebase_in(tb_wire), .timebase_oe_out,
        .timebase_out(), .fault_line_in(1'b1), .fault_shutdown_in, .uv_exceeded_in,
        .uv_fault_in(1'b0), .oc_active_in, .adc_low_in, .adc_high_in(1'b0),
        .vout_good_in, .power_good_out, .target_out, .dac_trim_out, .ccm_out,
        .three_state_out, .sink_en_out
    );

    ors_peer_model #(.TB_HALF(PER / 2)) u_peer
    (
        .clk_in, .hold_run_in(hold_run), .run_oe_out(peer_run_oe), .tb_level_out(peer_tb)
    );

    task automatic chk(input string what, input [15:0] exp, input [15:0] got);
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, got);
        end
    endtask

    task give_verdict;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // For a read, d is the value expected back
    task bus(input w, input r, input [3:0] a, input [15:0] d);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
        if (r)
            rexp.push_back(d);
        @(posedge clk_in);
    endtask

    task ramp(input up);
        for (i = 1; i <= 4; i = i + 1)
            texp.push_back(k * (up ? i[15:0] : 16'h4 - i[15:0]));
    endtask

    task drain;
        for (i = 0; i < 10 * PER && texp.size() > 0; i = i + 1)
            @(posedge clk_in);
        chk("ramp done", 16'h0, 16'(texp.size()));
    endtask

    // Delay is bounded loosely, from low up to the 10 * PER wait: tick phase is unknown to the bench
    task wmove(input integer low);
        reg [15:0] t0;
        t0 = target_out;
        for (i = 0; i < 10 * PER && target_out === t0; i = i + 1)
            @(posedge clk_in);
        chk("delay", 16'h1, {15'h0, i >= low && i < 10 * PER});
    endtask

    always @(posedge clk_in)
    begin
        rd_d <= rd_in;
        last_t <= target_out;
        if (rd_d)
            chk("rdata", rexp.pop_front(), rdata_out);
        if (mon_t && rstn_in && target_out !== last_t)
            chk("target", texp.size() > 0 ? texp.pop_front() : last_t, target_out);
    end

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    initial
    begin
        repeat (100000) @(posedge clk_in);
        errors = errors + 1;
        give_verdict;
    end

    initial
    begin
        void'($urandom(32'hea4defe1));
        k = 16'($urandom % 1000) + 16'h1;
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        bus(0, 1, 4'h0, 16'h0);
        bus(0, 1, 4'h7, 16'h0);
        bus(0, 1, 4'hf, 16'h0);
        bus(1, 0, 4'h9, 16'hffff);
        bus(0, 1, 4'h9, 16'h0);
        for (int a = 1; a < 7; a++)
        begin
            rv = 16'($urandom % 13000);
            bus(1, 0, a[3:0], rv);
            bus(0, 1, a[3:0], rv);
        end
        // same timing a sibling phase would be given
        bus(1, 0, 4'h1, 16'h3);
        bus(1, 0, 4'h2, 16'h4);
        bus(1, 0, 4'h3, 16'h2);
        bus(1, 0, 4'h4, 16'h4);
        bus(1, 0, 4'h5, {k[13:0], 2'b00});
        bus(1, 0, 4'h6, 16'h0);
        // servo enabled on this loop only
        bus(1, 0, 4'h7, 16'h0041);
        bus(1, 0, 4'h0, 16'h0001);
        bus(0, 0, 4'h0, 16'h0);
        init_done_in <= 1'b1;
        vin_above_on_in <= 1'b1;
        uv_exceeded_in <= 1'b1;
        adc_low_in <= 1'b1;
        repeat (5 * PER) @(posedge clk_in);
        chk("dut run oe", 16'h0, run_line_oe_out);
        chk("target held", 16'h0, target_out);
        ramp(1);
        hold_run <= 1'b0;
        wmove(2 * PER);
        chk("dcm in rise", 16'h0, ccm_out);
        drain();
        vout_good_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        vout_good_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("pg glitch", 16'h0, power_good_out);
        vout_good_in <= 1'b1;
        repeat (4 * SRV) @(posedge clk_in);
        chk("pg", 16'h1, power_good_out);
        chk("ccm", 16'h1, ccm_out);
        chk("stage on", 16'h0, three_state_out);
        chk("trim moved", 16'h1, {15'h0, dac_trim_out != 16'h0});
        ramp(0);
        bus(1, 0, 4'h0, 16'h0);
        bus(0, 0, 4'h0, 16'h0);
        wmove(PER);
        chk("sink on", 16'h1, sink_en_out);
        drain();
        repeat (2 * PER) @(posedge clk_in);
        chk("sink off", 16'h0, sink_en_out);
        bus(1, 0, 4'h7, 16'h0);
        bus(1, 0, 4'h2, 16'h2);
        bus(1, 0, 4'h6, 16'h2);
        oc_active_in <= 1'b1;
        bus(1, 0, 4'h0, 16'h0003);
        bus(0, 0, 4'h0, 16'h0);
        texp.push_back({k[13:0], 2'b00});
        drain();
        repeat (4 * PER) @(posedge clk_in);
        bus(0, 1, 4'h8, 16'h0053);
        oc_active_in <= 1'b0;
        bus(0, 0, 4'h0, 16'h0);
        bus(0, 1, 4'h8, 16'h00d3);
        bus(0, 0, 4'h0, 16'h0);
        ramp(0);
        hold_run <= 1'b1;
        drain();
        texp.push_back({k[13:0], 2'b00});
        hold_run <= 1'b0;
        drain();
        mon_t <= 1'b0;
        fault_shutdown_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("three state", 16'h1, three_state_out);
        vin_above_on_in <= 1'b0;
        vin_below_off_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk("timebase pull", 16'h1, timebase_oe_out);
        give_verdict;
    end
endmodule // testbench

bind ors_output_ramp_sequencer ors_checker
#(.PGOOD_FILT_CYC(PGOOD_FILT_CYC), .SERVO_CYC(SERVO_CYC)) u_chk
(
    .clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .init_done_in,
    .vin_below_off_in, .run_line_oe_out, .timebase_oe_out, .fault_shutdown_in,
    .vout_good_in, .power_good_out, .target_out, .dac_trim_out, .ccm_out,
    .three_state_out, .sink_en_out
);
